// File: dte_core_model.sv
// Cipher core stand-in that takes input blocks and hands back scrambled ones
`timescale 1ns/1ns
module dte_core_model (
    // Clock, reset and pacing
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    // Block in
    input wire logic blk_valid,
    input wire logic [63:0] blk_data,
    output logic blk_ready,
    // Block out
    input wire logic out_ready,
    output logic out_valid,
    output logic [63:0] out_data
);
    logic [63:0] held_reg;
    logic [3:0] wait_reg;
    logic full_reg;
    //==========================================================================
    // One block in flight, output held until taken
    always_ff @(posedge clk) begin
        blk_ready <= 1'h0;
        if (srst) begin
            full_reg <= 1'h0;
            out_valid <= 1'h0;
        end else begin
            if (out_valid && out_ready) begin
                out_valid <= 1'h0;
                out_data <= ~out_data;
            end else if (full_reg && !out_valid) begin
                if (wait_reg == 4'h0) begin
                    out_valid <= 1'h1;
                    out_data <= held_reg ^ 64'h5A5A_C3C3_5A5A_C3C3;
                    full_reg <= 1'h0;
                end else begin
                    wait_reg <= wait_reg - 4'h1;
                end
            end
            if (blk_valid && !blk_ready && !full_reg && !out_valid) begin
                blk_ready <= 1'h1;
                held_reg <= blk_data;
                full_reg <= 1'h1;
                wait_reg <= slow ? 4'h6 : 4'h0;
            end
        end
    end
endmodule

// File: dte_ctx_mem.sv
// Context word store with one write port and two registered read ports
`timescale 1ns/1ns
module dte_ctx_mem #(
    parameter int WORDS = 8,
    parameter int WIDTH = 32
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [$clog2(WORDS)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read ports, data one cycle after address
    input wire logic [$clog2(WORDS)-1:0] raddr_a,
    output logic [WIDTH-1:0] rdata_a,
    input wire logic [$clog2(WORDS)-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_b
);
    typedef struct packed {
        logic [WORDS-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd_a;
        logic [WIDTH-1:0] rd_b;
    } dte_mem_s;

    dte_mem_s s_reg;
    dte_mem_s s_next;

    // Refuse sizes the store cannot serve
    if (WORDS < 2 || WIDTH < 1) begin : g_bad_size
        $error("dte_ctx_mem: bad size");
    end

    // Write and read next values
    always_comb begin
        s_next = s_reg;
        if (we) s_next.mem[waddr] = wdata;
        s_next.rd_a = s_reg.mem[raddr_a];
        s_next.rd_b = s_reg.mem[raddr_b];
    end

    // Storage needs no reset; the soft reset sweep clears it
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign rdata_a = s_reg.rd_a;
    assign rdata_b = s_reg.rd_b;
endmodule

// File: dte_engine.sv
// DES/TDES engine context, length, soft reset, DMA and interrupt control
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module dte_engine
    import dte_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // AXI4-Lite register bus
    input wire dte_axi_req_s axi_req,
    output dte_axi_rsp_s axi_rsp,
    // Interrupt and DMA
    output logic irq,
    output logic [DMA_N-1:0] dma_req,
    input wire logic [DMA_N-1:0] dma_done,
    // Cipher core side
    output logic core_start,
    output dte_cfg_s core_cfg,
    output logic [31:0] core_len,
    output logic core_blk_valid,
    output logic [63:0] core_blk_data,
    input wire logic core_blk_ready,
    output logic core_out_ready,
    input wire logic core_out_valid,
    input wire logic [63:0] core_out_data,
    input wire logic [2:0] core_key_idx,
    output logic [31:0] core_key_word
);
    typedef struct packed {
        dte_state_e st;
        logic [2:0] cnt;
        dte_cfg_s cfg;
        logic [31:0] len;
        logic [31:0] remain;
        logic [31:0] out_remain;
        logic [DMA_N-1:0] dma_en;
        logic [IRQ_N-1:0] mask;
        logic [DMA_N-1:0] dma_sticky;
        logic [63:0] din;
        logic blk_valid;
        logic [63:0] dout;
        logic dout_empty;
        logic core_start;
        logic irq;
        logic [DMA_N-1:0] dma_req;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rd_wait;
        logic [7:0] raddr;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dte_regs_s;

    localparam dte_regs_s RST_STATE = '{st: ST_SRST, cfg: '{1'b0, mode_ecb, 1'b0},
        dout_empty: 1'b1, awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    dte_regs_s s_reg;
    dte_regs_s s_next;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic len_go;
    logic sr_go;

    // Byte count left after one block, never below zero
    function automatic logic [31:0] sub_blk(input logic [31:0] x);
        sub_blk = (x > BLOCK_BYTES) ? x - BLOCK_BYTES : 32'h0000_0000;
    endfunction

    // State flags {data out ready, data in ready, context ready}
    function automatic logic [2:0] flags(input dte_regs_s x);
        flags[0] = (x.st == ST_IDLE);
        flags[1] = (x.st == ST_RUN) && !x.blk_valid && (x.remain != 32'h0000_0000);
        flags[2] = !x.dout_empty;
    endfunction

    // Raw interrupt word
    function automatic logic [IRQ_N-1:0] raw_irq(input dte_regs_s x);
        raw_irq = {x.dma_sticky, flags(x)};
    endfunction

    // Address decode shared by read and write
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && ((a <= OFS_IRQ_MASKED) || (a[7:5] == CTX_SEL)
            || (a >= OFS_DIN_LO && a <= OFS_DOUT_HI));
    endfunction

    dte_ctx_mem #(
        .WORDS(CTX_WORDS),
        .WIDTH(32)
    ) u_ctx_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(axi_req.araddr[4:2]),
        .rdata_a(mem_rdata),
        .raddr_b(core_key_idx),
        .rdata_b(core_key_word)
    );

    // Next state of bus slave, context and engine control
    always_comb begin
        logic [2:0] fl;
        fl = flags(s_reg);
        s_next = s_reg;
        mem_we = 1'b0;
        mem_waddr = 3'h0;
        mem_wdata = 32'h0000_0000;
        len_go = 1'b0;
        sr_go = 1'b0;
        s_next.core_start = 1'b0;
        // Address and data capture, either order
        if (axi_req.awvalid && s_reg.awready) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_reg.wready) begin
            s_next.w_held = 1'b1;
            s_next.wdata = axi_req.wdata;
            s_next.wstrb = axi_req.wstrb;
        end
        if (s_reg.bvalid && axi_req.bready) s_next.bvalid = 1'b0;
        // Core hand-offs
        if (s_reg.blk_valid && core_blk_ready) s_next.blk_valid = 1'b0;
        if (core_out_valid && s_reg.dout_empty) begin
            s_next.dout = core_out_data;
            s_next.dout_empty = 1'b0;
        end
        // Register write once address and data are both held
        if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            if (!is_mapped(s_reg.awaddr) || s_reg.wstrb != 4'hF) begin
                s_next.bresp = RESP_SLVERR;
            end else if (s_reg.awaddr[7:5] == CTX_SEL) begin
                if (fl[0]) begin
                    mem_we = 1'b1;
                    mem_waddr = s_reg.awaddr[4:2];
                    mem_wdata = s_reg.wdata;
                end
            end else begin
                case (s_reg.awaddr)
                    OFS_CFG: begin
                        if (fl[0]) begin
                            s_next.cfg.encrypt = s_reg.wdata[CFG_DIR_BIT];
                            s_next.cfg.triple = s_reg.wdata[CFG_TRIPLE_BIT];
                            if (s_reg.wdata[CFG_MODE_LSB+:2] != 2'h3) begin
                                s_next.cfg.mode = dte_mode_e'(s_reg.wdata[CFG_MODE_LSB+:2]);
                            end
                        end
                    end
                    OFS_LEN: begin
                        if (fl[0]) begin
                            s_next.len = s_reg.wdata;
                            s_next.remain = s_reg.wdata;
                            s_next.out_remain = s_reg.wdata;
                            if (s_reg.wdata != 32'h0000_0000) begin
                                s_next.st = ST_RUN;
                                s_next.core_start = 1'b1;
                                len_go = 1'b1;
                            end
                        end
                    end
                    OFS_SOFT_RST: sr_go = s_reg.wdata[0] && (s_reg.st != ST_SRST);
                    OFS_DMA_EN: s_next.dma_en = s_reg.wdata[DMA_N-1:0];
                    OFS_IRQ_RAW: begin
                        s_next.dma_sticky = s_reg.dma_sticky & ~s_reg.wdata[IRQ_N-1:IRQ_DMA_LSB];
                    end
                    OFS_IRQ_MASK: s_next.mask = s_reg.wdata[IRQ_N-1:0];
                    OFS_DIN_LO: if (fl[1]) s_next.din[31:0] = s_reg.wdata;
                    OFS_DIN_HI: begin
                        if (fl[1]) begin
                            s_next.din[63:32] = s_reg.wdata;
                            s_next.blk_valid = 1'b1;
                            s_next.remain = sub_blk(s_reg.remain);
                        end
                    end
                    default: s_next.bresp = RESP_OKAY;
                endcase
            end
        end
        // Read: address taken, memory word ready next cycle, then answer
        if (axi_req.arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.raddr = axi_req.araddr;
            s_next.rd_wait = 1'b1;
        end
        if (s_reg.rd_wait) begin
            s_next.rd_wait = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = is_mapped(s_reg.raddr) ? RESP_OKAY : RESP_SLVERR;
            s_next.rdata = 32'h0000_0000;
            case (s_reg.raddr)
                OFS_CFG: begin
                    s_next.rdata[CFG_DIR_BIT] = s_reg.cfg.encrypt;
                    s_next.rdata[CFG_MODE_LSB+:2] = s_reg.cfg.mode;
                    s_next.rdata[CFG_TRIPLE_BIT] = s_reg.cfg.triple;
                    s_next.rdata[CFG_CTX_RDY_BIT] = fl[0];
                    s_next.rdata[CFG_IN_RDY_BIT] = fl[1];
                    s_next.rdata[CFG_OUT_RDY_BIT] = fl[2];
                    s_next.rdata[CFG_BUSY_BIT] = (s_reg.st == ST_RUN);
                end
                OFS_LEN: s_next.rdata = s_reg.len;
                OFS_SOFT_RST: s_next.rdata[0] = (s_reg.st == ST_SRST);
                OFS_DMA_EN: s_next.rdata[DMA_N-1:0] = s_reg.dma_en;
                OFS_IRQ_RAW: s_next.rdata[IRQ_N-1:0] = raw_irq(s_reg);
                OFS_IRQ_MASK: s_next.rdata[IRQ_N-1:0] = s_reg.mask;
                OFS_IRQ_MASKED: s_next.rdata[IRQ_N-1:0] = raw_irq(s_reg) & s_reg.mask;
                OFS_DOUT_LO: s_next.rdata = s_reg.dout[31:0];
                OFS_DOUT_HI: begin
                    s_next.rdata = s_reg.dout[63:32];
                    if (!s_reg.dout_empty) begin
                        s_next.dout_empty = 1'b1;
                        s_next.out_remain = sub_blk(s_reg.out_remain);
                    end
                end
                default: begin
                    // Vector words read back, key words read as zero
                    if (s_reg.raddr[7:3] == {CTX_SEL, IV_BASE_IDX[2:1]}) s_next.rdata = mem_rdata;
                end
            endcase
        end
        if (s_reg.rvalid && axi_req.rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // Engine sequencing
        unique case (s_reg.st)
            ST_IDLE: s_next.cnt = 3'h0;
            ST_RUN: if (s_next.out_remain == 32'h0000_0000) s_next.st = ST_IDLE;
            ST_SRST: begin
                mem_we = 1'b1;
                mem_waddr = s_reg.cnt;
                mem_wdata = 32'h0000_0000;
                s_next.cnt = s_reg.cnt + 3'h1;
                if (s_reg.cnt == SRST_LAST) s_next.st = ST_IDLE;
            end
            default: s_next.st = ST_SRST;
        endcase
        // Soft reset clears control, context and data state
        if (sr_go) begin
            s_next.st = ST_SRST;
            s_next.cnt = 3'h0;
            s_next.cfg = RST_STATE.cfg;
            s_next.len = 32'h0000_0000;
            s_next.remain = 32'h0000_0000;
            s_next.out_remain = 32'h0000_0000;
            s_next.dma_en = '0;
            s_next.mask = '0;
            s_next.dma_sticky = '0;
            s_next.din = 64'h0000_0000_0000_0000;
            s_next.blk_valid = 1'b0;
            s_next.dout = 64'h0000_0000_0000_0000;
            s_next.dout_empty = 1'b1;
        end
        // DMA done events win over a clear in the same cycle
        s_next.dma_sticky = s_next.dma_sticky | dma_done;
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.dma_req = s_next.dma_en & flags(s_next);
        s_next.irq = |(raw_irq(s_next) & s_next.mask);
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign axi_rsp = '{s_reg.awready, s_reg.wready, s_reg.bvalid, s_reg.bresp,
        s_reg.arready, s_reg.rvalid, s_reg.rdata, s_reg.rresp};
    assign irq = s_reg.irq;
    assign dma_req = s_reg.dma_req;
    assign core_start = s_reg.core_start;
    assign core_cfg = s_reg.cfg;
    assign core_len = s_reg.len;
    assign core_blk_valid = s_reg.blk_valid;
    assign core_blk_data = s_reg.din;
    assign core_out_ready = s_reg.dout_empty;

    //==========================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_IRQ_GATE: assert property (irq == |(raw_irq(s_reg) & s_reg.mask))
        else $error("irq does not match masked status");
    AST_CTX_GUARD: assert property (mem_we |-> s_reg.st != ST_RUN)
        else $error("context written while engine busy");
    AST_LEN_START: assert property (len_go |=> core_start && s_reg.st == ST_RUN)
        else $error("length write did not start the engine");
    AST_START_PULSE: assert property (core_start |=> !core_start)
        else $error("start is longer than one cycle");
    AST_SRST_SWEEP: assert property ($rose(s_reg.st == ST_SRST)
        |-> (s_reg.st == ST_SRST)[*8] ##1 s_reg.st == ST_IDLE)
        else $error("soft reset sweep length wrong");
    AST_DMA_STICKY: assert property (dma_done[0] |=> s_reg.dma_sticky[0])
        else $error("DMA done event lost");
    AST_DMA_REQ: assert property (dma_req == (s_reg.dma_en & flags(s_reg)))
        else $error("DMA request not gated by enable");
    AST_IN_PACE: assert property (core_blk_valid |-> (flags(s_reg) & 3'h2) == 3'h0)
        else $error("input ready while block pending");
    AST_MODE_LEGAL: assert property (s_reg.cfg.mode != 2'h3)
        else $error("illegal chaining mode stored");
    AST_RD_LAT: assert property (axi_req.arvalid && axi_rsp.arready |-> ##2 axi_rsp.rvalid)
        else $error("read answer late");

    COV_START: cover property (len_go ##[1:20] s_reg.st == ST_IDLE);
    COV_SRST: cover property (sr_go);
    COV_IRQ: cover property ($rose(irq));
    COV_BLOCK: cover property (core_blk_valid && core_blk_ready);
endmodule

// File: dte_engine_test.sv
// Self-checking testbench of the DES/TDES context engine
`timescale 1ns/1ns
module dte_engine_test;
    import dte_pkg::*;
    typedef struct {logic [31:0] d; logic [1:0] r; bit cd; string nm;} dte_note_s;
    localparam logic [7:0] IV0_ADDR = 8'h38;
    localparam logic [63:0] PAT = 64'h5A5A_C3C3_5A5A_C3C3;
    logic clk, srst, irq, core_start, core_blk_valid, core_blk_ready, slow;
    logic core_out_ready, core_out_valid;
    dte_axi_req_s axi_req;
    dte_axi_rsp_s axi_rsp;
    dte_cfg_s core_cfg;
    logic [2:0] dma_req, dma_done, core_key_idx;
    logic [31:0] core_len, core_key_word, rdat, cv, key [8];
    logic [63:0] core_blk_data, core_out_data, blk;
    logic [1:0] em;
    logic [7:0] zr [6] = '{OFS_LEN, OFS_DMA_EN, OFS_IRQ_MASK, OFS_IRQ_MASKED, 8'h38, 8'h3C};
    int n_errors = 0, check_count = 0, cycles = 0, starts = 0;
    dte_note_s notes [$];
    dte_note_s mon;
    dte_engine dut_u (.clk(clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp), .irq(irq),
        .dma_req(dma_req), .dma_done(dma_done), .core_start(core_start), .core_cfg(core_cfg),
        .core_len(core_len), .core_blk_valid(core_blk_valid), .core_blk_data(core_blk_data),
        .core_blk_ready(core_blk_ready), .core_out_ready(core_out_ready),
        .core_out_valid(core_out_valid), .core_out_data(core_out_data),
        .core_key_idx(core_key_idx), .core_key_word(core_key_word));
    dte_core_model core_u (.clk(clk), .srst(srst), .slow(slow), .blk_valid(core_blk_valid),
        .blk_data(core_blk_data), .blk_ready(core_blk_ready), .out_ready(core_out_ready),
        .out_valid(core_out_valid), .out_data(core_out_data));
    //==========================================================================
    // Clock
    always #25 clk = ~clk;
    //==========================================================================
    // Compare, verdict and bus tasks
    task automatic check(string nm, logic [63:0] exp, logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v, logic [3:0] s = 4'hF, logic [1:0] r = 2'h0);
        notes.push_back('{v, r, 1'h0, $sformatf("write %h", a)});
        axi_req.awvalid <= 1'h1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'h1;
        axi_req.wdata <= v;
        axi_req.wstrb <= s;
        axi_req.bready <= 1'h1;
        do begin
            @(posedge clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'h0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'h0;
        end while (!(axi_rsp.bvalid && axi_req.bready));
        axi_req.bready <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, bit cd = 1, logic [1:0] r = 2'h0);
        notes.push_back('{e, r, cd, $sformatf("read %h", a)});
        axi_req.arvalid <= 1'h1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'h1;
        do begin
            @(posedge clk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'h0;
        end while (!(axi_rsp.rvalid && axi_req.rready));
        rdat = axi_rsp.rdata;
        axi_req.rready <= 1'h0;
        @(posedge clk);
    endtask
    task automatic poll(int b);
        do rd(OFS_CFG, '0, 0); while (rdat[b] !== 1'h1);
    endtask
    //==========================================================================
    // Response monitor, start counter and hang limit
    always @(posedge clk) begin
        if ((axi_rsp.bvalid && axi_req.bready) || (axi_rsp.rvalid && axi_req.rready)) begin
            mon = notes.pop_front();
            check({mon.nm, " resp"}, mon.r, axi_rsp.rvalid ? axi_rsp.rresp : axi_rsp.bresp);
            if (mon.cd) check(mon.nm, mon.d, axi_rsp.rdata);
        end
        if (core_start === 1'h1) starts++;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    //==========================================================================
    // Main sequence
    initial begin
        clk = 1'h0;
        srst = 1'h1;
        slow = 1'h0;
        axi_req = '0;
        dma_done = '0;
        core_key_idx = '0;
        em = 2'h0;
        void'($urandom(98));
        repeat (10) @(posedge clk);
        srst <= 1'h0;
        poll(CFG_CTX_RDY_BIT);
        rd(OFS_IRQ_RAW, 32'h1);
        foreach (zr[i]) rd(zr[i], '0);
        // Every direction, mode and width, code 3 keeps the mode
        for (int i = 0; i < 16; i++) begin
            cv = i;
            if (cv[2:1] == 2'h3) cv[2:1] = em;
            em = cv[2:1];
            wr(OFS_CFG, i);
            rd(OFS_CFG, cv | 32'h10);
            check("core_cfg", cv[3:0], core_cfg);
        end
        // Soft reset, configuration, key words, vector words and their readback
        wr(OFS_SOFT_RST, 32'h1);
        poll(CFG_CTX_RDY_BIT);
        wr(OFS_CFG, 32'h3);
        for (int i = 0; i < 8; i++) begin
            key[i] = $urandom;
            wr(8'h20 + 8'(4 * i), key[i]);
            rd(8'h20 + 8'(4 * i), i < 6 ? '0 : key[i]);
        end
        for (int i = 0; i < 8; i++) begin
            core_key_idx <= 3'(i);
            repeat (2) @(posedge clk);
            check("key word", key[i], core_key_word);
        end
        rd(8'h80, '0, 1, RESP_SLVERR);
        wr(8'h84, 32'h1, 4'hF, RESP_SLVERR);
        wr(IV0_ADDR, ~key[6], 4'h3, RESP_SLVERR);
        wr(OFS_DMA_EN, 32'h7);
        check("dma_req idle", 3'h1, dma_req);
        // Two-block run, second answered slowly; vector write refused meanwhile
        wr(OFS_LEN, 32'h10);
        check("core_len", 32'h10, core_len);
        check("starts", 1, starts);
        rd(OFS_CFG, 32'hA3);
        check("dma_req run", 3'h2, dma_req);
        wr(IV0_ADDR, 32'h0);
        for (int b = 0; b < 2; b++) begin
            slow <= b[0];
            blk = {$urandom, $urandom};
            poll(CFG_IN_RDY_BIT);
            wr(OFS_DIN_LO, blk[31:0]);
            wr(OFS_DIN_HI, blk[63:32]);
            poll(CFG_OUT_RDY_BIT);
            rd(OFS_DOUT_LO, blk[31:0] ^ PAT[31:0]);
            rd(OFS_DOUT_HI, blk[63:32] ^ PAT[63:32]);
        end
        rd(OFS_CFG, 32'h13);
        rd(IV0_ADDR, key[6]);
        // DMA done events, masking and clearing
        wr(OFS_IRQ_MASK, 32'h8);
        for (int i = 0; i < 3; i++) begin
            dma_done <= 3'h1 << i;
            @(posedge clk);
            dma_done <= 3'h0;
            @(posedge clk);
        end
        rd(OFS_IRQ_RAW, 32'h39);
        rd(OFS_IRQ_MASKED, 32'h8);
        check("irq set", 1'h1, irq);
        wr(OFS_IRQ_RAW, 32'h7);
        rd(OFS_IRQ_RAW, 32'h39);
        wr(OFS_IRQ_RAW, 32'h8);
        rd(OFS_IRQ_RAW, 32'h31);
        check("irq cleared", 1'h0, irq);
        wr(OFS_IRQ_MASK, 32'h1);
        rd(OFS_IRQ_MASKED, 32'h1);
        check("irq level", 1'h1, irq);
        // Largest length, then a soft reset aborts the run
        wr(OFS_LEN, 32'hFFFF_FFFF);
        rd(OFS_LEN, 32'hFFFF_FFFF);
        check("starts", 2, starts);
        wr(OFS_SOFT_RST, 32'h1);
        poll(CFG_CTX_RDY_BIT);
        rd(OFS_CFG, 32'h10);
        rd(OFS_IRQ_RAW, 32'h1);
        foreach (zr[i]) rd(zr[i], '0);
        check("irq after soft reset", 1'h0, irq);
        give_verdict();
    end
endmodule

// File: dte_pkg.sv
// Constants, types and register map of the DES/TDES context engine
//==============================================================================
package dte_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_LEN = 8'h04;
    localparam logic [7:0] OFS_SOFT_RST = 8'h08;
    localparam logic [7:0] OFS_DMA_EN = 8'h0C;
    localparam logic [7:0] OFS_IRQ_RAW = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASKED = 8'h18;
    localparam logic [7:0] OFS_DIN_LO = 8'h40;
    localparam logic [7:0] OFS_DIN_HI = 8'h44;
    localparam logic [7:0] OFS_DOUT_LO = 8'h48;
    localparam logic [7:0] OFS_DOUT_HI = 8'h4C;
    // Context window 0x20..0x3C: key words 0..5, vector words 6..7
    localparam logic [2:0] CTX_SEL = 3'h1;
    localparam logic [2:0] IV_BASE_IDX = 3'h6;
    localparam int KEY_WORDS = 6;
    localparam int IV_WORDS = 2;
    localparam int CTX_WORDS = KEY_WORDS + IV_WORDS;
    // Configuration and status field positions
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam int CFG_TRIPLE_BIT = 3;
    localparam int CFG_CTX_RDY_BIT = 4;
    localparam int CFG_IN_RDY_BIT = 5;
    localparam int CFG_OUT_RDY_BIT = 6;
    localparam int CFG_BUSY_BIT = 7;
    // Interrupt bits: 2:0 follow engine state, 5:3 sticky DMA done
    localparam int IRQ_N = 6;
    localparam int DMA_N = 3;
    localparam int IRQ_DMA_LSB = 3;
    // Block size in bytes and last word count of the soft reset sweep
    localparam logic [31:0] BLOCK_BYTES = 32'h0000_0008;
    localparam logic [2:0] SRST_LAST = 3'h7;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        mode_ecb = 2'b00,
        chained_block_mode = 2'b01,
        mode_cfb = 2'b10
    } dte_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SRST = 2'b10
    } dte_state_e;

    typedef struct packed {
        logic triple;
        dte_mode_e mode;
        logic encrypt;
    } dte_cfg_s;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } dte_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dte_axi_rsp_s;
endpackage
